/* hw/lcsr_regs.sv */
// control and status registers of the line interface and voice codec
// assumes a classic wishbone master and single-clock event pulses
`timescale 1ns/1ps
`default_nettype none
module lcsr_regs
    import lcsr_pkg::*;
#(
    parameter int unsigned TIMER_W = TIMER_PEND_W,
    parameter int unsigned LINE_W = LINE_PEND_W
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // automatic power control from the analog sequencer
    input wire logic AUTO_CONV_OFF_I,
    input wire logic AUTO_PLL_FREERUN_I,
    input wire logic AUTO_BIAS_OFF_I,
    input wire logic AUTO_LINE_OFF_I,
    input wire logic AUTO_ADC_ON_I,
    input wire logic AUTO_DAC_ON_I,
    input wire logic AUTO_TRANSAMP_ON_I,
    // event pulses
    input wire logic [TIMER_W-1:0] EVT_TIMER_I,
    input wire logic [LINE_W-1:0] EVT_LINE_I,
    // hybrid balance controls
    output logic [2:0] METER_GAIN_SEL_O,
    output logic METER_HYB_EN_O,
    output logic [2:0] AUDIO_GAIN_SEL_O,
    output logic AUDIO_HYB_EN_O,
    // effective power controls
    output logic CONV_OFF_O,
    output logic PLL_FREERUN_O,
    output logic BIAS_OFF_O,
    output logic LINE_OFF_O,
    output logic ADC_ON_O,
    output logic DAC_ON_O,
    output logic TRANSAMP_ON_O,
    // masked interrupt request
    output logic INT_O
);

    typedef struct packed {
        lcsr_bus_type bus;
        logic [7:0] dat;
        logic [7:0] hyb;
        logic [7:0] pwr1;
        logic [7:0] pwr2;
        logic [TIMER_W-1:0] ten;
        logic [LINE_W-1:0] len;
        logic meter_en;
        logic audio_en;
        logic conv_off;
        logic pll_fr;
        logic bias_off;
        logic line_off;
        logic adc_on;
        logic dac_on;
        logic gm_on;
    } lcsr_state_type;

    lcsr_state_type r;
    lcsr_state_type next_r;

    logic [5:0] idx;
    logic req;
    logic wr_now;
    logic low_lane;
    logic [7:0] wdat;
    logic [TIMER_W-1:0] tpend;
    logic [LINE_W-1:0] lpend;
    logic tirq;
    logic lirq;
    logic [7:0] rd_mux;

    // bus decode; only the low byte lane carries register data
    assign idx = ADR_I[7:2];
    assign req = CYC_I & STB_I;
    assign low_lane = SEL_I[0];
    assign wdat = DAT_I[7:0];
    // writes land on the edge at which the master sees ack
    assign wr_now = req & WE_I & low_lane & (r.bus == BUS_ACK);

    // timer pending flags: ringing, oscillator two, oscillator one
    lcsr_pend #(
        .WIDTH(TIMER_W)
    ) u_timer_pend (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .set_i(EVT_TIMER_I),
        .clr_wr_i(wr_now && idx == IDX_TIMER_PEND),
        .clr_mask_i(wdat[TIMER_W-1:0]),
        .en_i(r.ten),
        .pend_o(tpend),
        .irq_o(tirq)
    );

    // line pending flags: alarms six..one, hook change, ring trip
    lcsr_pend #(
        .WIDTH(LINE_W)
    ) u_line_pend (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .set_i(EVT_LINE_I),
        .clr_wr_i(wr_now && idx == IDX_LINE_PEND),
        .clr_mask_i(wdat[LINE_W-1:0]),
        .en_i(r.len),
        .pend_o(lpend),
        .irq_o(lirq)
    );

    // read multiplexer; unmapped indices answer zero
    always_comb begin
        rd_mux = 8'h00;
        case (idx)
            IDX_HYBRID: begin
                rd_mux = r.hyb & HYBRID_MASK;
            end
            IDX_PWR_OVR: begin
                rd_mux = r.pwr1 & PWR_OVR_MASK;
            end
            IDX_CONV_PWR: begin
                rd_mux = r.pwr2 & CONV_PWR_MASK;
            end
            IDX_TIMER_PEND: begin
                rd_mux[TIMER_W-1:0] = tpend;
            end
            IDX_LINE_PEND: begin
                rd_mux[LINE_W-1:0] = lpend;
            end
            IDX_TIMER_EN: begin
                rd_mux[TIMER_W-1:0] = r.ten;
            end
            IDX_LINE_EN: begin
                rd_mux[LINE_W-1:0] = r.len;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // next state: bus handshake, register writes, power outputs
    always_comb begin
        next_r = r;
        case (r.bus)
            BUS_IDLE: begin
                if (req) begin
                    next_r.bus = BUS_ACK;
                    next_r.dat = rd_mux;
                end
            end
            BUS_ACK: begin
                // always one idle cycle, so ack never doubles up
                next_r.bus = BUS_IDLE;
            end
            default: begin
                next_r.bus = BUS_IDLE;
            end
        endcase
        if (wr_now) begin
            case (idx)
                IDX_HYBRID: begin
                    next_r.hyb = wdat & HYBRID_MASK;
                end
                IDX_PWR_OVR: begin
                    next_r.pwr1 = wdat & PWR_OVR_MASK;
                end
                IDX_CONV_PWR: begin
                    next_r.pwr2 = wdat & CONV_PWR_MASK;
                end
                IDX_TIMER_EN: begin
                    next_r.ten = wdat[TIMER_W-1:0];
                end
                IDX_LINE_EN: begin
                    next_r.len = wdat[LINE_W-1:0];
                end
                default: begin
                    next_r.hyb = next_r.hyb;
                end
            endcase
        end
        // balance off code disables the hybrid path
        next_r.meter_en = next_r.hyb[METER_BALANCE_SEL_LSB +: 3]
            != BALANCE_OFF_CODE;
        next_r.audio_en = next_r.hyb[AUDIO_BALANCE_SEL_LSB +: 3]
            != BALANCE_OFF_CODE;
        // overrides win over automatic control
        next_r.conv_off = r.pwr1[CONVERTER_FORCE_OFF_POS]
            | AUTO_CONV_OFF_I;
        next_r.pll_fr = r.pwr1[PLL_FORCE_FREERUN_POS]
            | AUTO_PLL_FREERUN_I;
        next_r.bias_off = r.pwr1[BIAS_FORCE_OFF_POS]
            | AUTO_BIAS_OFF_I;
        next_r.line_off = r.pwr1[LINE_DRIVER_FORCE_OFF_POS]
            | AUTO_LINE_OFF_I;
        // manual select hands the on bit control
        next_r.adc_on = r.pwr2[ADC_MANUAL_SEL_POS]
            ? r.pwr2[ADC_POWER_ON_POS] : AUTO_ADC_ON_I;
        next_r.dac_on = r.pwr2[DAC_MANUAL_SEL_POS]
            ? r.pwr2[DAC_POWER_ON_POS] : AUTO_DAC_ON_I;
        next_r.gm_on = r.pwr2[TRANSAMP_MANUAL_SEL_POS]
            ? r.pwr2[TRANSAMP_POWER_ON_POS] : AUTO_TRANSAMP_ON_I;
    end

    // state register; outputs settle one edge after their cause, power outputs two edges after a register write
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            r.bus <= BUS_IDLE;
            r.dat <= 8'h00;
            r.hyb <= HYBRID_RST;
            r.pwr1 <= PWR_OVR_RST;
            r.pwr2 <= CONV_PWR_RST;
            r.ten <= EN_RST[TIMER_W-1:0];
            r.len <= EN_RST[LINE_W-1:0];
            r.meter_en <= 1'b1;
            r.audio_en <= 1'b1;
            r.conv_off <= 1'b1;
            r.pll_fr <= 1'b0;
            r.bias_off <= 1'b1;
            r.line_off <= 1'b1;
            r.adc_on <= 1'b0;
            r.dac_on <= 1'b0;
            r.gm_on <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // output drive
    assign DAT_O = {24'h000000, r.dat};
    assign ACK_O = (r.bus == BUS_ACK) & req;
    assign METER_GAIN_SEL_O = r.hyb[METER_BALANCE_SEL_LSB +: 3];
    assign METER_HYB_EN_O = r.meter_en;
    assign AUDIO_GAIN_SEL_O = r.hyb[AUDIO_BALANCE_SEL_LSB +: 3];
    assign AUDIO_HYB_EN_O = r.audio_en;
    assign CONV_OFF_O = r.conv_off;
    assign PLL_FREERUN_O = r.pll_fr;
    assign BIAS_OFF_O = r.bias_off;
    assign LINE_OFF_O = r.line_off;
    assign ADC_ON_O = r.adc_on;
    assign DAC_ON_O = r.dac_on;
    assign TRANSAMP_ON_O = r.gm_on;
    assign INT_O = tirq | lirq;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    // a write to the hybrid register shows on the selects next cycle
    chk_meter_code_write: assert property (
        (wr_now && idx == IDX_HYBRID) |=>
        (METER_GAIN_SEL_O == $past(DAT_I[6:4])))
        else $error("meter balance code not taken");
    chk_audio_off_code: assert property (
        (wr_now && idx == IDX_HYBRID && DAT_I[2:0] == 3'h7) |=>
        (AUDIO_GAIN_SEL_O == 3'h7 && !AUDIO_HYB_EN_O))
        else $error("audio hybrid not off for code 7");
    chk_conv_override: assert property (
        r.pwr1[CONVERTER_FORCE_OFF_POS] |=> CONV_OFF_O)
        else $error("converter not forced off");
    chk_pll_freerun: assert property (
        !r.pwr1[PLL_FORCE_FREERUN_POS] |=>
        (PLL_FREERUN_O == $past(AUTO_PLL_FREERUN_I)))
        else $error("pll free-run not automatic");
    chk_bias_line_off: assert property (
        (r.pwr1[BIAS_FORCE_OFF_POS] && r.pwr1[LINE_DRIVER_FORCE_OFF_POS])
        |=> (BIAS_OFF_O && LINE_OFF_O))
        else $error("bias or line driver not forced off");
    chk_adc_manual: assert property (
        r.pwr2[ADC_MANUAL_SEL_POS] |=>
        (ADC_ON_O == $past(r.pwr2[ADC_POWER_ON_POS])))
        else $error("adc ignores manual on bit");
    chk_adc_auto: assert property (
        !r.pwr2[ADC_MANUAL_SEL_POS] |=> (ADC_ON_O == $past(AUTO_ADC_ON_I)))
        else $error("adc not automatic");
    chk_dac_select: assert property (
        1'b1 |=> (DAC_ON_O == ($past(r.pwr2[DAC_MANUAL_SEL_POS])
            ? $past(r.pwr2[DAC_POWER_ON_POS]) : $past(AUTO_DAC_ON_I))))
        else $error("dac power select wrong");
    chk_transamp_select: assert property (
        1'b1 |=> (TRANSAMP_ON_O == ($past(r.pwr2[TRANSAMP_MANUAL_SEL_POS])
            ? $past(r.pwr2[TRANSAMP_POWER_ON_POS])
            : $past(AUTO_TRANSAMP_ON_I))))
        else $error("transamp power select wrong");
    chk_timer_event: assert property (
        EVT_TIMER_I[5] |=> tpend[5])
        else $error("ringing idle event not pending");
    chk_alarm_event: assert property (
        (EVT_LINE_I != '0) |=> ((lpend & $past(EVT_LINE_I))
            == $past(EVT_LINE_I)))
        else $error("line event not pending");
    chk_pend_clear: assert property (
        (wr_now && idx == IDX_LINE_PEND && DAT_I[0] && !EVT_LINE_I[0])
        |=> !lpend[0])
        else $error("ring trip not cleared by one");
    chk_reserved_zero: assert property (
        (ACK_O && !WE_I && ADR_I[7:2] == IDX_HYBRID) |->
        (DAT_O[7] == 1'b0 && DAT_O[3] == 1'b0 && DAT_O[31:8] == 24'h0))
        else $error("reserved bits read nonzero");
    chk_ack_single: assert property (
        ACK_O |=> !ACK_O)
        else $error("ack held two cycles");
    chk_ack_latency: assert property (
        (req && r.bus == BUS_IDLE) |=> ACK_O)
        else $error("ack not one cycle after request");

    // main scenarios
    cov_hybrid_write: cover property (wr_now && idx == IDX_HYBRID);
    cov_irq_rise: cover property (!INT_O ##1 INT_O);
    cov_adc_manual: cover property (
        r.pwr2[ADC_MANUAL_SEL_POS] ##1 ADC_ON_O);
    cov_pend_clear: cover property (
        lpend[1] ##1 (wr_now && idx == IDX_LINE_PEND) ##1 !lpend[1]);

endmodule // lcsr_regs
`default_nettype wire

/* hw/lcsr_pkg.sv */
// constants for the line codec control and status register bank
// assumes a classic wishbone slave with 32-bit data, byte addresses
// What this block does
// - read/write 3-bit pulse metering balance code in bits 6:4; 111 turns it off
// - read/write 3-bit audio balance code in bits 2:0; 011 is 0 dB, 111 off
// - converter off bit 4 set forces converter off, else automatic control
// - pll free-run bit 3 set forces free-run, else automatic control
// - bias off bit 1 set forces dc bias off, else automatic control
// - line driver off bit 0 set forces it off, else automatic control
// - adc manual bit 5 set takes adc power from its on bit
// - adc on bit 4 powers adc only in manual mode, ignored otherwise
// - dac manual bit 3 selects manual mode, dac on bit 2 then applies
// - transamp manual bit 1 selects manual mode, bit 0 then applies
// - ringing idle and active timer pending flags at bits 5 and 4
// - oscillator two flags at bits 3:2, oscillator one at bits 1:0
// - six power alarm pending flags, six down to one, bits 7 to 2
// - hook change pending flag at bit 1 of second pending register
// - ring trip pending flag at bit 0 of second pending register
// - writing 1 to a pending flag clears it and withdraws it
// - each pending flag has an enable bit masking it from the output
package lcsr_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_HYBRID = 6'h0B;
    localparam logic [5:0] IDX_PWR_OVR = 6'h0E;
    localparam logic [5:0] IDX_CONV_PWR = 6'h0F;
    localparam logic [5:0] IDX_TIMER_PEND = 6'h12;
    localparam logic [5:0] IDX_LINE_PEND = 6'h13;
    localparam logic [5:0] IDX_TIMER_EN = 6'h15;
    localparam logic [5:0] IDX_LINE_EN = 6'h16;

    // field positions, hybrid balance register
    localparam int METER_BALANCE_SEL_LSB = 4;
    localparam int AUDIO_BALANCE_SEL_LSB = 0;
    localparam logic [2:0] BALANCE_OFF_CODE = 3'h7;
    localparam logic [2:0] BALANCE_ZERO_DB = 3'h3;

    // field positions, power override register
    localparam int CONVERTER_FORCE_OFF_POS = 4;
    localparam int PLL_FORCE_FREERUN_POS = 3;
    localparam int BIAS_FORCE_OFF_POS = 1;
    localparam int LINE_DRIVER_FORCE_OFF_POS = 0;

    // field positions, converter power register
    localparam int ADC_MANUAL_SEL_POS = 5;
    localparam int ADC_POWER_ON_POS = 4;
    localparam int DAC_MANUAL_SEL_POS = 3;
    localparam int DAC_POWER_ON_POS = 2;
    localparam int TRANSAMP_MANUAL_SEL_POS = 1;
    localparam int TRANSAMP_POWER_ON_POS = 0;

    // implemented bits of each register; the rest read zero
    localparam logic [7:0] HYBRID_MASK = 8'h77;
    localparam logic [7:0] PWR_OVR_MASK = 8'h1B;
    localparam logic [7:0] CONV_PWR_MASK = 8'h3F;

    // pending flag counts
    localparam int unsigned TIMER_PEND_W = 6;
    localparam int unsigned LINE_PEND_W = 8;

    // values after reset
    localparam logic [7:0] HYBRID_RST = 8'h00;
    localparam logic [7:0] PWR_OVR_RST = 8'h00;
    localparam logic [7:0] CONV_PWR_RST = 8'h00;
    localparam logic [7:0] PEND_RST = 8'h00;
    localparam logic [7:0] EN_RST = 8'h00;

    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } lcsr_bus_type;

endpackage

/* hw/lcsr_pend.sv */
// bank of sticky pending flags with write-one-to-clear and enables
// assumes set pulses and the clear strobe share the one clock
`timescale 1ns/1ps
`default_nettype none
module lcsr_pend
    import lcsr_pkg::*;
#(
    parameter int unsigned WIDTH = LINE_PEND_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // hardware events and software clear
    input wire logic [WIDTH-1:0] set_i,
    input wire logic clr_wr_i,
    input wire logic [WIDTH-1:0] clr_mask_i,
    input wire logic [WIDTH-1:0] en_i,
    // flags and masked request
    output logic [WIDTH-1:0] pend_o,
    output logic irq_o
);

    typedef struct packed {
        logic [WIDTH-1:0] pend;
    } lcsr_pend_state_type;

    lcsr_pend_state_type r;
    lcsr_pend_state_type next_r;
    logic [WIDTH-1:0] next_bit;

    // set beats a clear in the same cycle, so no event is lost
    genvar k;
    generate
        for (k = 0; k < WIDTH; k++) begin : g_flag
            assign next_bit[k] = set_i[k] |
                (r.pend[k] & ~(clr_wr_i & clr_mask_i[k]));
        end
    endgenerate

    // next state
    always_comb begin
        next_r = r;
        next_r.pend = next_bit;
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.pend <= PEND_RST[WIDTH-1:0];
        end else begin
            r <= next_r;
        end
    end

    // masked flags onto one request line
    assign pend_o = r.pend;
    assign irq_o = |(r.pend & en_i);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_set_wins: assert property (
        (set_i != '0) |=> ((r.pend & $past(set_i)) == $past(set_i)))
        else $error("pending flag lost its set");
    chk_clear_one: assert property (
        (clr_wr_i && set_i == '0) |=> ((r.pend & $past(clr_mask_i)) == '0))
        else $error("pending flag not cleared by a one");
    // exact next value: kept flags minus cleared ones, plus new events
    chk_zero_keeps: assert property (
        1'b1 |=> (r.pend == (($past(r.pend)
            & ~$past(clr_wr_i ? clr_mask_i : '0)) | $past(set_i))))
        else $error("pending flag changed without cause");
    chk_mask_gate: assert property (
        ((r.pend & en_i) == '0) |-> !irq_o)
        else $error("masked flag reached request");
    chk_enable_pass: assert property (
        ((set_i & en_i) != '0) ##1 (en_i == $past(en_i)) |-> irq_o)
        else $error("enabled flag did not reach request");
    cov_set_clear: cover property (
        (r.pend != '0) ##1 clr_wr_i ##1 (r.pend == '0));

endmodule // lcsr_pend
`default_nettype wire

/* tb/test_lcsr_regs.sv */
// self-checking bench for the line codec control and status registers
// assumes lcsr_pkg is compiled first; the bench alone masters the bus
`timescale 1ns/1ps
`default_nettype none
module test_lcsr_regs;
    import lcsr_pkg::*;

    logic clk, rst, cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r;
    logic ack, irq;
    logic [6:0] auto;
    logic [5:0] evt_t;
    logic [7:0] evt_l;
    logic [2:0] m_sel, a_sel;
    logic m_en, a_en, conv_off, pll_fr, bias_off, line_off;
    logic adc_on, dac_on, gm_on;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;

    lcsr_regs u_lcsr_regs (
        .CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
        .ACK_O(ack), .AUTO_CONV_OFF_I(auto[6]),
        .AUTO_PLL_FREERUN_I(auto[5]), .AUTO_BIAS_OFF_I(auto[4]),
        .AUTO_LINE_OFF_I(auto[3]), .AUTO_ADC_ON_I(auto[2]),
        .AUTO_DAC_ON_I(auto[1]), .AUTO_TRANSAMP_ON_I(auto[0]),
        .EVT_TIMER_I(evt_t), .EVT_LINE_I(evt_l),
        .METER_GAIN_SEL_O(m_sel), .METER_HYB_EN_O(m_en),
        .AUDIO_GAIN_SEL_O(a_sel), .AUDIO_HYB_EN_O(a_en),
        .CONV_OFF_O(conv_off), .PLL_FREERUN_O(pll_fr),
        .BIAS_OFF_O(bias_off), .LINE_OFF_O(line_off), .ADC_ON_O(adc_on),
        .DAC_ON_O(dac_on), .TRANSAMP_ON_O(gm_on), .INT_O(irq)
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // a hang must still reach the verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            error_cnt++;
            $display("timeout at %0t", $time);
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    // one classic cycle; request held until the edge that sees ack
    task automatic wb(input logic w, input logic [5:0] idx,
                      input logic [7:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dat_w <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, 4'hF, q);
        chk(q, {24'h000000, exp});
    endtask

    // power outputs lag the register by one more cycle
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask

    task automatic pulse(input logic [5:0] t, input logic [7:0] l);
        @(posedge clk);
        evt_t <= t;
        evt_l <= l;
        @(posedge clk);
        evt_t <= 6'h00;
        evt_l <= 8'h00;
    endtask

    initial begin
        logic [2:0] m, a;
        logic [3:0] f;
        logic [5:0] c, pi, ei;
        logic [7:0] all, b;
        logic [31:0] q;
        logic x;
        {cyc, stb, we, adr, sel, dat_w, auto, evt_t, evt_l} = '0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // registers after reset
        rd_chk(IDX_HYBRID, HYBRID_RST);
        rd_chk(IDX_PWR_OVR, PWR_OVR_RST);
        rd_chk(IDX_CONV_PWR, CONV_PWR_RST);
        rd_chk(IDX_TIMER_PEND, PEND_RST);
        rd_chk(IDX_LINE_PEND, PEND_RST);
        $display("test reset finished");
        // every balance code, reserved bits written high
        for (int k = 0; k < 8; k++) begin
            m = k[2:0];
            a = ~m;
            wr(IDX_HYBRID, {1'b1, m, 1'b1, a});
            settle();
            chk(32'({m_en, m_sel, a_en, a_sel}),
                32'({m != 3'h7, m, a != 3'h7, a}));
            rd_chk(IDX_HYBRID, {1'b0, m, 1'b0, a});
        end
        wb(1'b1, IDX_HYBRID, 8'h33, 4'hE, q);
        rd_chk(IDX_HYBRID, 8'h70);
        wr(6'h00, 8'hFF);
        rd_chk(6'h00, 8'h00);
        $display("test hybrid finished");
        // force bits against both automatic levels
        for (int i = 0; i < 32; i++) begin
            f = i[3:0];
            x = i[4];
            auto <= {7{x}};
            wr(IDX_PWR_OVR, {3'b111, f[3], f[2], 1'b1, f[1], f[0]});
            settle();
            chk(32'({conv_off, pll_fr, bias_off, line_off}), 32'(f | {4{x}}));
            rd_chk(IDX_PWR_OVR, {3'b000, f[3], f[2], 1'b0, f[1], f[0]});
        end
        $display("test override finished");
        // manual and automatic converter power
        for (int i = 0; i < 128; i++) begin
            c = i[5:0];
            x = i[6];
            auto <= {7{x}};
            wr(IDX_CONV_PWR, {2'b11, c});
            settle();
            chk(32'({adc_on, dac_on, gm_on}), 32'({c[5] ? c[4] : x, c[3] ? c[2] : x, c[1] ? c[0] : x}));
            rd_chk(IDX_CONV_PWR, {2'b00, c});
        end
        $display("test converter finished");
        // pending flags of both registers
        for (int r = 0; r < 2; r++) begin
            pi = (r == 1) ? IDX_LINE_PEND : IDX_TIMER_PEND;
            ei = (r == 1) ? IDX_LINE_EN : IDX_TIMER_EN;
            all = (r == 1) ? 8'hFF : 8'h3F;
            for (int k = 0; k < 8; k++) begin
                b = 8'h01 << k;
                if ((b & all) != 8'h00) begin
                    pulse((r == 1) ? 6'h00 : b[5:0], (r == 1) ? b : 8'h00);
                    rd_chk(pi, b);
                    wr(pi, b);
                    rd_chk(pi, 8'h00);
                end
            end
            pulse((r == 1) ? 6'h00 : 6'h3F, (r == 1) ? 8'hFF : 8'h00);
            wr(pi, 8'h00);
            rd_chk(pi, all);
            chk(32'(irq), 32'h0);
            wr(ei, 8'h01);
            rd_chk(ei, 8'h01);
            chk(32'(irq), 32'h1);
            wr(pi, 8'h01);
            @(posedge clk);
            chk(32'(irq), 32'h0);
            rd_chk(pi, all & 8'hFE);
            // a fresh enabled event raises the request again
            pulse((r == 1) ? 6'h00 : 6'h01, (r == 1) ? 8'h01 : 8'h00);
            @(posedge clk);
            chk(32'(irq), 32'h1);
            wr(pi, all);
            rd_chk(pi, 8'h00);
            wr(ei, 8'h00);
        end
        $display("test pending finished");
        give_verdict();
    end
endmodule // test_lcsr_regs
`default_nettype wire
